/* rtl/gecm_defines.vh */
// Constants for the gated edge count measure block
// =============================================================
// Summary of operation
// - Single pulse-width: count source while gate active, latch on inactive, then stop.
// - Buffered pulse-width: latch accumulated count on every trailing gate edge.
// - Buffered modes forward latched values in order toward host memory; a value latched while the held word is not yet taken is dropped as overrun.
// - Period measured between two rising or between two falling gate edges.
// - Source edge polarity counted is selectable, rising or falling.
// - Single period: latch on second active gate edge, then ignore everything.
// - Buffered period: latch count at end of every gate period.
// - Semi-period: interval between any two consecutive gate edges.
// - Single semi-period behaves exactly like single pulse-width.
// - Buffered semi-period: latch count on every gate edge.
// - Nothing starts before arming; earlier gate and source activity ignored.
// - Fast reference timebase selectable as source for one-period frequency.
// - Count and save registers are 32 bits wide.
`ifndef GECM_DEFINES_VH
`define GECM_DEFINES_VH

// =============================================================
// Register byte offsets
`define GECM_CTRL_OFS 8'h00
`define GECM_STAT_OFS 8'h04
`define GECM_COUNT_OFS 8'h08
`define GECM_SAVE_OFS 8'h0C
`define GECM_IRQ_STAT_OFS 8'h10
`define GECM_IRQ_MASK_OFS 8'h14
`define GECM_HOST_DATA_OFS 8'h18

// =============================================================
// Control fields
`define GECM_CTRL_ARM 0
`define GECM_CTRL_MODE_LO 1
`define GECM_CTRL_MODE_HI 3
`define GECM_CTRL_BUFFERED 4
`define GECM_CTRL_GATE_LOW 5
`define GECM_CTRL_SRC_FALL 6
`define GECM_CTRL_SRC_SEL_LO 7
`define GECM_CTRL_SRC_SEL_HI 8

// Mode encodings
`define GECM_MODE_PULSE 3'h0
`define GECM_MODE_PERIOD 3'h1
`define GECM_MODE_SEMI 3'h2

// Source select encodings
`define GECM_SRC_EXT 2'h0
`define GECM_SRC_FAST 2'h1
`define GECM_SRC_SLOW 2'h2

// Interrupt status bits
`define GECM_IRQ_DONE 0
`define GECM_IRQ_SAMPLE 1
`define GECM_IRQ_OVERRUN 2

`define GECM_CTRL_RESET 32'h00000000
`define GECM_SLOW_DIV 16'h0FA0

`endif

/* rtl/gecm_top.v */
// Gated edge count measurement core with AXI4-Lite register slave
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
module gecm_top
(
	input wire aclk, // Clock, 125 MHz
	input wire aresetn, // Synchronous reset, active low
	input wire gate_in, // Gate signal
	input wire source_in, // External source signal
	input wire fast_reference_timebase, // Fast internal reference clock level
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	output reg [31:0] host_data, // Buffered sample toward host memory
	output reg host_valid, // Sample valid
	input wire host_ready, // Host path accepts sample
	output reg irq // Interrupt, active high level
);
`include "gecm_defines.vh"

	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_RUN = 2'd2;
	localparam ST_DONE = 2'd3;

	reg [31:0] ctrl;
	reg [31:0] count;
	reg [31:0] save;
	reg [2:0] irq_stat;
	reg [2:0] irq_mask;
	reg [1:0] state;
	reg gate_d;
	reg src_d;
	reg done;
	reg slow_tb;
	reg [15:0] slow_cnt;
	reg [7:0] awaddr_q;
	reg aw_have;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_have;

	wire [2:0] mode = ctrl[`GECM_CTRL_MODE_HI:`GECM_CTRL_MODE_LO];
	wire buffered = ctrl[`GECM_CTRL_BUFFERED];
	wire gate_low = ctrl[`GECM_CTRL_GATE_LOW];
	wire src_fall = ctrl[`GECM_CTRL_SRC_FALL];
	wire [1:0] src_sel = ctrl[`GECM_CTRL_SRC_SEL_HI:`GECM_CTRL_SRC_SEL_LO];

	// =============================================================
	// Source selection and edge detection
	reg src_now;
	always @*
	begin
		case (src_sel)
			`GECM_SRC_FAST: src_now = fast_reference_timebase;
			`GECM_SRC_SLOW: src_now = slow_tb;
			default: src_now = source_in;
		endcase
	end

	// Slow timebase derived from the clock, for signals below the fast range
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			slow_cnt <= 16'h0000;
			slow_tb <= 1'b0;
		end
		else if (slow_cnt == `GECM_SLOW_DIV)
		begin
			slow_cnt <= 16'h0000;
			slow_tb <= ~slow_tb;
		end
		else
			slow_cnt <= slow_cnt + 16'h0001;
	end

	function edge_of;
		input now;
		input prev;
		input fall;
		begin
			edge_of = fall ? (prev & ~now) : (now & ~prev);
		end
	endfunction

	// Gate level mapped so that 1 is the active level
	wire gate_act = gate_in ^ gate_low;
	wire gate_act_d = gate_d ^ gate_low;
	wire src_edge = edge_of(src_now, src_d, src_fall);
	wire gate_lead = edge_of(gate_act, gate_act_d, 1'b0);
	wire gate_trail = edge_of(gate_act, gate_act_d, 1'b1);
	wire gate_any = gate_in ^ gate_d;
	// Single semi-period is single pulse-width
	wire pulse_like = (mode == `GECM_MODE_PULSE) || (mode == `GECM_MODE_SEMI && !buffered);

	// =============================================================
	// Bus decode helpers
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_have && w_have && !s_axi_bvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire wr_ctrl = do_write && awaddr_q == `GECM_CTRL_OFS;
	wire arm_write = wr_ctrl && wstrb_q[0] && wdata_q[`GECM_CTRL_ARM];
	wire rd_save = ar_take && s_axi_araddr == `GECM_SAVE_OFS;
	wire rd_irq = ar_take && s_axi_araddr == `GECM_IRQ_STAT_OFS;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// The arm decision must see the mode written together with the arm bit
	wire [31:0] ctrl_wr = merge(ctrl, wdata_q, wstrb_q) & 32'h000001FE;
	wire run_at_arm = ctrl_wr[`GECM_CTRL_BUFFERED] &&
		(ctrl_wr[`GECM_CTRL_MODE_HI:`GECM_CTRL_MODE_LO] != `GECM_MODE_PULSE);
	wire [31:0] mask_wr = merge({29'h00000000, irq_mask}, wdata_q, wstrb_q);

	// =============================================================
	// Measurement engine
	reg latch;
	reg next_stop;
	always @*
	begin
		latch = 1'b0;
		next_stop = 1'b0;
		if (state == ST_RUN)
		begin
			if (pulse_like)
			begin
				latch = gate_trail;
				next_stop = !buffered;
			end
			else if (mode == `GECM_MODE_PERIOD)
			begin
				latch = gate_lead;
				next_stop = !buffered;
			end
			else
				latch = gate_any;
		end
	end

	// Buffered period and semi-period count from arm, so the first sample is partial
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_IDLE;
			count <= 32'h00000000;
			save <= 32'h00000000;
			done <= 1'b0;
			gate_d <= 1'b0;
			src_d <= 1'b0;
		end
		else
		begin
			gate_d <= gate_in;
			src_d <= src_now;
			if (arm_write)
			begin
				// Re-arm restarts the count and drops the done flag
				count <= 32'h00000000;
				done <= 1'b0;
				state <= run_at_arm ? ST_RUN : ST_WAIT;
			end
			else
			begin
				if (rd_save)
					done <= 1'b0;
				case (state)
					ST_WAIT:
					begin
						// Pulse modes wait for a fresh active edge; period waits for first edge
						if (gate_lead)
						begin
							state <= ST_RUN;
							count <= pulse_like ? {31'h00000000, src_edge} : 32'h00000000;
						end
					end
					ST_RUN:
					begin
						if (latch)
						begin
							save <= count;
							if (next_stop)
							begin
								state <= ST_DONE;
								done <= 1'b1;
							end
							if (pulse_like || mode == `GECM_MODE_PULSE)
								count <= 32'h00000000;
							else
								count <= {31'h00000000, src_edge};
						end
						else if (src_edge && (!pulse_like || gate_act))
							count <= count + 32'h00000001;
					end
					ST_DONE: state <= ST_DONE;
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// =============================================================
	// Host transfer: one held word; a new sample while held counts as overrun
	wire sample_evt = (state == ST_RUN) && latch && buffered;
	wire host_full = host_valid && !host_ready;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			host_valid <= 1'b0;
			host_data <= 32'h00000000;
		end
		else if (sample_evt && !host_full)
		begin
			host_valid <= 1'b1;
			host_data <= count;
		end
		else if (host_ready)
			host_valid <= 1'b0;
	end

	// =============================================================
	// Interrupt status, set wins over read clear
	wire [2:0] irq_set = {sample_evt && host_full, sample_evt, (state == ST_RUN) && latch && next_stop};
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			irq_stat <= (rd_irq ? 3'h0 : irq_stat) | irq_set;
			irq <= |(((rd_irq ? 3'h0 : irq_stat) | irq_set) & irq_mask);
		end
	end

	// =============================================================
	// AXI4-Lite slave
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			ctrl <= `GECM_CTRL_RESET;
			irq_mask <= 3'h0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_have <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_have <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				if (wr_ctrl)
					ctrl <= ctrl_wr;
				else if (awaddr_q == `GECM_IRQ_MASK_OFS)
					irq_mask <= mask_wr[2:0];
				else if (awaddr_q != `GECM_STAT_OFS && awaddr_q != `GECM_COUNT_OFS &&
					awaddr_q != `GECM_SAVE_OFS && awaddr_q != `GECM_IRQ_STAT_OFS &&
					awaddr_q != `GECM_HOST_DATA_OFS)
					s_axi_bresp <= 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end
		else if (ar_take)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				`GECM_CTRL_OFS: s_axi_rdata <= ctrl;
				`GECM_STAT_OFS: s_axi_rdata <= {28'h0000000, host_valid, state, done};
				`GECM_COUNT_OFS: s_axi_rdata <= count;
				`GECM_SAVE_OFS: s_axi_rdata <= save;
				`GECM_IRQ_STAT_OFS: s_axi_rdata <= {29'h00000000, irq_stat};
				`GECM_IRQ_MASK_OFS: s_axi_rdata <= {29'h00000000, irq_mask};
				`GECM_HOST_DATA_OFS: s_axi_rdata <= host_data;
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // gecm_top

/* verif/gecm_sva.sv */
// Port checker for the gated edge count measure block
module gecm_sva
(
	input wire aclk, // Clock
	input wire aresetn, // Reset
	input wire s_axi_awvalid, // AW valid
	input wire s_axi_awready, // AW ready
	input wire s_axi_wvalid, // W valid
	input wire s_axi_wready, // W ready
	input wire s_axi_bvalid, // B valid
	input wire s_axi_bready, // B ready
	input wire s_axi_arvalid, // AR valid
	input wire s_axi_arready, // AR ready
	input wire s_axi_rvalid, // R valid
	input wire s_axi_rready, // R ready
	input wire [31:0] host_data, // Sample
	input wire host_valid, // Sample valid
	input wire host_ready, // Sample taken
	input wire irq // Interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ============
	// Stream and bus answers
	a_host_hold: assert property (host_valid && !host_ready
		|=> host_valid && $stable(host_data)) else $error("sample lost");
	a_reset_idle: assert property ($rose(aresetn) |-> !host_valid && !irq)
		else $error("busy after reset");
	a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read");
	// Both halves are registered first, so the response shows on the second edge
	a_write_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("late write");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write not refused");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("double write answer");
	a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("double read answer");
	a_rdy_back: assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
		else $error("readies stuck");
endmodule // gecm_sva

/* verif/gecm_far.sv */
// Model of gate, source, fast timebase and host path around the block
module gecm_far
(
	input wire aclk, // Clock
	output logic gate_in, // Gate level
	output logic source_in, // Source level
	output logic fast_reference_timebase, // Fast reference
	output logic host_ready // Host accepts
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		gate_in = 1'h0;
		source_in = 1'h0;
		fast_reference_timebase = 1'h0;
		host_ready = 1'h1;
	end
	// ============
	// Free running timebase
	always @(posedge aclk)
		fast_reference_timebase <= ~fast_reference_timebase;
	// Two clocks high, two low, so each pulse sits inside one gate level
	task src(input int n);
		repeat (n)
		begin
			source_in <= 1'h1;
			repeat (2) @(posedge aclk);
			source_in <= 1'h0;
			repeat (2) @(posedge aclk);
		end
	endtask
	task set_gate(input logic v, input logic st);
		gate_in <= v;
		if (st)
			host_ready <= 1'h0;
		repeat (6) @(posedge aclk);
		if (st)
			host_ready <= 1'h1;
	endtask
endmodule // gecm_far

/* verif/testbench.sv */
// Self-checking bench for the gated edge count measure block
`include "gecm_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, host_data, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_valid, host_ready, irq;
	logic gate_in, source_in, fast_reference_timebase;
	logic [31:0] got[$];
	logic [31:0] exp_s[0:7] = '{32'h3, 32'h1, 32'h1, 32'h5, 32'h1, 32'h3, 32'h2, 32'h1};
	int exp_o[0:2] = '{0, 2, 4};
	int exp_n[0:2] = '{2, 2, 4};
	int err_total = 0, n_tests = 0;
	always #4 aclk = ~aclk;
	gecm_top u_dut (.aclk, .aresetn, .gate_in, .source_in, .fast_reference_timebase,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .host_data, .host_valid, .host_ready, .irq);
	gecm_far u_far (.aclk, .gate_in, .source_in, .fast_reference_timebase, .host_ready);
	always @(posedge aclk)
		if (aresetn && host_valid && host_ready)
			got.push_back(host_data);
	// ============
	// Bus, check and finish tasks
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask
	task tmo(input int i);
		if (i >= 200)
		begin
			$display("MISMATCH bus_wait exp answer got timeout");
			err_total++;
			test_done;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 200; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'h0;
		rr = s_axi_bresp;
		tmo(i);
	endtask
	task rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 200; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'h0;
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		tmo(i);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg_%h", a), e, rv & m);
	endtask
	// ============
	// Scenarios
	initial
	begin
		int m, p, e;
		aresetn <= 1'h0;
		s_axi_awaddr <= 8'h00;
		s_axi_araddr <= 8'h00;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		s_axi_bready <= 1'h0;
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		u_far.src(2);
		u_far.set_gate(1'h1, 1'h0);
		u_far.src(1);
		u_far.set_gate(1'h0, 1'h0);
		rc(`GECM_COUNT_OFS, 32'hFFFFFFFF, 32'h0);
		rc(`GECM_STAT_OFS, 32'h1, 32'h0);
		wr(8'h20, 32'h0);
		chk("bresp_unmapped", 32'h2, {30'h0, rr});
		rd(8'h1C);
		chk("rresp_unmapped", 32'h2, {30'h0, rr});
		wr(`GECM_IRQ_MASK_OFS, 32'h1);
		rc(`GECM_IRQ_MASK_OFS, 32'h7, 32'h1);
		// No strobe set: the mask must keep its value
		s_axi_wstrb <= 4'h0;
		wr(`GECM_IRQ_MASK_OFS, 32'h7);
		s_axi_wstrb <= 4'hF;
		rc(`GECM_IRQ_MASK_OFS, 32'h7, 32'h1);
		$display("test setup done");
		for (m = 0; m < 3; m++)
			for (p = 0; p < 2; p++)
			begin
				u_far.set_gate(p[0], 1'h0);
				wr(`GECM_CTRL_OFS, 32'h1 | m << 1 | p << 5 | p << 6);
				u_far.src(1);
				u_far.set_gate(!p[0], 1'h0);
				u_far.src(3);
				u_far.set_gate(p[0], 1'h0);
				u_far.src(2);
				u_far.set_gate(!p[0], 1'h0);
				u_far.src(1);
				u_far.set_gate(p[0], 1'h0);
				chk("irq", 32'h1, {31'h0, irq});
				rc(`GECM_IRQ_STAT_OFS, 32'h7, 32'h1);
				rc(`GECM_SAVE_OFS, 32'hFFFFFFFF, m == 1 ? 32'h5 : 32'h3);
				rc(`GECM_STAT_OFS, 32'h1, 32'h0);
				chk("irq_clear", 32'h0, {31'h0, irq});
				$display("test single mode %0d pol %0d done", m, p);
			end
		// A 40 clock gate period holds 20 fast rises; one of 4*(DIV+1) clocks holds 2 slow rises
		for (m = 1; m < 3; m++)
		begin
			p = m == 1 ? 14 : 2 * (`GECM_SLOW_DIV + 1) - 6;
			e = m == 1 ? 20 : 2;
			u_far.set_gate(1'h0, 1'h0);
			wr(`GECM_CTRL_OFS, 32'h3 | m << 7);
			u_far.set_gate(1'h1, 1'h0);
			repeat (p) @(posedge aclk);
			u_far.set_gate(1'h0, 1'h0);
			repeat (p) @(posedge aclk);
			u_far.set_gate(1'h1, 1'h0);
			rd(`GECM_SAVE_OFS);
			chk("timebase_period", 32'h1, {31'h0, rv >= e - 1 && rv <= e + 1});
			$display("test timebase %0d done", m);
		end
		for (m = 0; m < 3; m++)
		begin
			u_far.set_gate(1'h0, 1'h0);
			got.delete();
			wr(`GECM_CTRL_OFS, 32'h11 | m << 1);
			u_far.src(1);
			u_far.set_gate(1'h1, 1'h1);
			u_far.src(3);
			u_far.set_gate(1'h0, 1'h0);
			u_far.src(2);
			u_far.set_gate(1'h1, 1'h0);
			u_far.src(1);
			u_far.set_gate(1'h0, 1'h0);
			chk("sample_count", exp_n[m], got.size());
			for (p = 0; p < got.size() && p < exp_n[m]; p++)
				chk("sample", exp_s[exp_o[m] + p], got[p]);
			// Partial first samples are kept above only to check them; a consumer drops them
			if (m > 0)
				void'(got.pop_front());
			$display("test buffered mode %0d done", m);
		end
		// Done from the timebase runs and sample from the buffered runs, no overrun
		rc(`GECM_IRQ_STAT_OFS, 32'h7, 32'h3);
		test_done;
	end
endmodule // testbench
bind gecm_top gecm_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .host_data, .host_valid, .host_ready, .irq);
